/* rss_cfg.svh */
// Offsets, field positions, reset values and timing counts of the sequencer.
// Assumes a 100 MHz system clock and an AXI4-Lite register bus.
//
// Behaviour
// - A span holds at most eight regenerators; addresses fit that limit.
// - Regenerator is two halves, office-facing and terminal-facing, linked internally.
// - X regenerators give X+1 segments, each with its own start-up.
// - Terminal half: idle, remote start to hold A, no probing to wait-office.
// - With probing, terminal half returns to idle and waits office-tagged margins.
// - Office start: hold B; with office margins go check, flag set.
// - Regenerator-initiated start treated exactly as office-initiated start.
// - Entering wait-office or hold A sends caps notice and caps list.
// - Sent caps are own and peer caps intersected bitwise, and with probing caps too when probing is enabled.
// - Terminal half reuses mode received with office-up notice next session.
// - Terminal 4-minute timer expiry before active: idle, report link failure.
// - Either half fails to idle when handshake not done in 30 s.
// - Fallback flag plus failure in wait-office: terminal half starts session two.
// - With probing, office half enters session one once margins held.
// - Office half sends link-start notice entering wait-remote or hold B.
// - Forward margins only from office transceiver or flagged peer.
// - Office half sends office-up notice with its mode on active entry.
// - Clock mode 1 may signal active early; other modes after activation.
// - Office half advertises own caps intersected with received caps list.
// - Office 4-minute timer expiry before active: idle, report link failure.
// - Fallback flag plus failure in wait-remote: office half starts session two.
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

`define RSS_MAX_REGEN     8
`define RSS_OFF_CTRL      32'h00000000
`define RSS_OFF_CAPS      32'h00000004
`define RSS_OFF_STATUS    32'h00000008
`define RSS_OFF_ADVCAPS   32'h0000000C
`define RSS_OFF_MODE      32'h00000010
`define RSS_CTRL_PROBE    0
`define RSS_CTRL_DIAG     1
`define RSS_CTRL_CMODE    2
`define RSS_CTRL_ADDR     4
`define RSS_CTRL_FBMODE   8
`define RSS_ST_TFAIL      12
`define RSS_ST_OFAIL      13
`define RSS_CTRL_RST      32'h00000000
`define RSS_CAPS_RST      32'hFFFFFFFF
`define RSS_CLK_NS        10
`define RSS_TICK_NS       1000000
`define RSS_TICK_CYCLES   (`RSS_TICK_NS / `RSS_CLK_NS)
`define RSS_LONG_MIN      4
`define RSS_LONG_TICKS    (`RSS_LONG_MIN * 60 * 1000)
`define RSS_HS_S          30
`define RSS_HS_TICKS      (`RSS_HS_S * 1000)

`endif

/* rss_pkg.sv */
// Types shared by the regenerator start-up sequencer.
// Assumes rss_cfg.svh holds the numeric constants.
package rss_pkg;
	typedef enum logic [2:0] {
		T_INITIAL_IDLE   = 3'h0,
		T_HOLDA   = 3'h1,
		T_HOLDB   = 3'h2,
		T_CHECK   = 3'h3,
		T_WAITOFF = 3'h4,
		T_SESS2   = 3'h5,
		T_ACTIVE  = 3'h6
	} rss_term_state_type;

	typedef enum logic [2:0] {
		O_INITIAL_IDLE   = 3'h0,
		O_HOLDA   = 3'h1,
		O_HOLDB   = 3'h2,
		O_SESS1   = 3'h3,
		O_WAITREM = 3'h4,
		O_SESS2   = 3'h5,
		O_ACTIVE  = 3'h6
	} rss_office_state_type;

	typedef enum logic [1:0] {
		CM_1  = 2'h0,
		CM_2  = 2'h1,
		CM_3A = 2'h2,
		CM_3B = 2'h3
	} rss_clk_mode_type;
endpackage

/* rss_top.sv */
// Start-up sequencer for both halves of one signal regenerator.
// Assumes handshake engines give one-cycle event pulses, levels otherwise.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "rss_cfg.svh"

module rss_top #(
	parameter int CAP_W       = 16,
	parameter int MODE_W      = 8,
	parameter int MARGIN_W    = 8,
	parameter int TICK_CYCLES = `RSS_TICK_CYCLES,
	parameter int LONG_TICKS  = `RSS_LONG_TICKS,
	parameter int HS_TICKS    = `RSS_HS_TICKS
)(
	input  wire logic                             clk,
	input  wire logic                             reset_n,
	input  wire logic [31:0]                      awaddr,
	input  wire logic                             awvalid,
	output logic                                  awready,
	input  wire logic [31:0]                      wdata,
	input  wire logic [3:0]                       wstrb,
	input  wire logic                             wvalid,
	output logic                                  wready,
	output logic [1:0]                            bresp,
	output logic                                  bvalid,
	input  wire logic                             bready,
	input  wire logic [31:0]                      araddr,
	input  wire logic                             arvalid,
	output logic                                  arready,
	output logic [31:0]                           rdata,
	output logic [1:0]                            rresp,
	output logic                                  rvalid,
	input  wire logic                             rready,
	input  wire logic                             tRemoteInit,
	input  wire logic                             tOfficeInit,
	input  wire logic [CAP_W-1:0]                 tPeerCaps,
	input  wire logic [CAP_W-1:0]                 tProbeCaps,
	input  wire logic                             tSessOk,
	input  wire logic                             tActDone,
	input  wire logic                             tHsFail,
	input  wire logic                             oOfficeInit,
	input  wire logic                             oMarginValid,
	input  wire logic [MARGIN_W-1:0]              oMargin,
	input  wire logic                             oPeerIsOffice,
	input  wire logic                             oPeerMarginFlag,
	input  wire logic [MODE_W-1:0]                oMode,
	input  wire logic                             oSessOk,
	input  wire logic                             oActStart,
	input  wire logic                             oActDone,
	input  wire logic                             oHsFail,
	output rss_pkg::rss_term_state_type           tState,
	output rss_pkg::rss_office_state_type         oState,
	output logic [CAP_W-1:0]                      tAdvCaps,
	output logic                                  officeMarginFlag,
	output logic [MARGIN_W-1:0]                   tMargin,
	output logic [MODE_W-1:0]                     tModeSel,
	output logic                                  tStartHs,
	output logic [CAP_W-1:0]                      oAdvCaps,
	output logic                                  oStartHs,
	output logic                                  capsReadyNote,
	output logic                                  linkStartNote,
	output logic                                  officeUpNote,
	output logic                                  tFailNote,
	output logic                                  oFailNote
);
	import rss_pkg::*;

	localparam int PW = $clog2(TICK_CYCLES + 1);
	localparam int LW = $clog2(LONG_TICKS + 1);
	localparam int HW = $clog2(HS_TICKS + 1);
	localparam int AW = $clog2(`RSS_MAX_REGEN);

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	logic        awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt, doWrite, wrMapped;
	logic [31:0] awAddr_r, awAddr_nxt, wData_r, wData_nxt, rdMux;
	logic [3:0]  wStrb_r, wStrb_nxt;
	logic        awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
	logic [1:0]  bresp_nxt, rresp_nxt;
	logic [31:0] rdata_nxt;
	logic        rdMapped;

	assign doWrite  = awHeld_r && wHeld_r && !bvalid;
	assign wrMapped = awAddr_r == `RSS_OFF_CTRL || awAddr_r == `RSS_OFF_CAPS ||
		awAddr_r == `RSS_OFF_STATUS || awAddr_r == `RSS_OFF_ADVCAPS ||
		awAddr_r == `RSS_OFF_MODE;

	always_comb begin
		awHeld_nxt = awHeld_r;
		awAddr_nxt = awAddr_r;
		wHeld_nxt  = wHeld_r;
		wData_nxt  = wData_r;
		wStrb_nxt  = wStrb_r;
		bvalid_nxt = bvalid;
		bresp_nxt  = bresp;
		rvalid_nxt = rvalid;
		rdata_nxt  = rdata;
		rresp_nxt  = rresp;
		if (awvalid && awready) begin
			awHeld_nxt = 1'b1;
			awAddr_nxt = {awaddr[31:2], 2'h0};
		end
		if (wvalid && wready) begin
			wHeld_nxt = 1'b1;
			wData_nxt = wdata;
			wStrb_nxt = wstrb;
		end
		if (bvalid && bready)
			bvalid_nxt = 1'b0;
		if (doWrite) begin
			bvalid_nxt = 1'b1;
			bresp_nxt  = wrMapped ? 2'h0 : 2'h2;
			awHeld_nxt = 1'b0;
			wHeld_nxt  = 1'b0;
		end
		if (rvalid && rready)
			rvalid_nxt = 1'b0;
		if (arvalid && arready) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = rdMux;
			rresp_nxt  = rdMapped ? 2'h0 : 2'h2;
		end
		awready_nxt = !awHeld_nxt && !bvalid_nxt;
		wready_nxt  = !wHeld_nxt && !bvalid_nxt;
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			awHeld_r <= 1'b0;
			awAddr_r <= 32'h00000000;
			wHeld_r  <= 1'b0;
			wData_r  <= 32'h00000000;
			wStrb_r  <= 4'h0;
			awready  <= 1'b0;
			wready   <= 1'b0;
			bvalid   <= 1'b0;
			bresp    <= 2'h0;
			arready  <= 1'b0;
			rvalid   <= 1'b0;
			rdata    <= 32'h00000000;
			rresp    <= 2'h0;
		end else begin
			awHeld_r <= awHeld_nxt;
			awAddr_r <= awAddr_nxt;
			wHeld_r  <= wHeld_nxt;
			wData_r  <= wData_nxt;
			wStrb_r  <= wStrb_nxt;
			awready  <= awready_nxt;
			wready   <= wready_nxt;
			bvalid   <= bvalid_nxt;
			bresp    <= bresp_nxt;
			arready  <= arready_nxt;
			rvalid   <= rvalid_nxt;
			rdata    <= rdata_nxt;
			rresp    <= rresp_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration and sticky failure status
	logic [31:0] ctrl_r, ctrl_nxt, caps_r, caps_nxt, wMask;
	logic        tFailSt_r, tFailSt_nxt, oFailSt_r, oFailSt_nxt;
	logic        probeEn, diagEn;
	logic [1:0]  clkMode;
	logic [AW-1:0] regenAddr;
	logic [MODE_W-1:0] fbMode;
	logic [MODE_W-1:0] oModeSel_r, officeMode_r;

	assign probeEn   = ctrl_r[`RSS_CTRL_PROBE];
	assign diagEn    = ctrl_r[`RSS_CTRL_DIAG];
	assign clkMode   = ctrl_r[`RSS_CTRL_CMODE +: 2];
	assign regenAddr = ctrl_r[`RSS_CTRL_ADDR +: AW];
	assign fbMode    = ctrl_r[`RSS_CTRL_FBMODE +: MODE_W];
	assign wMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}},
		{8{wStrb_r[1]}}, {8{wStrb_r[0]}}};

	always_comb begin
		ctrl_nxt    = ctrl_r;
		caps_nxt    = caps_r;
		tFailSt_nxt = tFailSt_r;
		oFailSt_nxt = oFailSt_r;
		if (doWrite && awAddr_r == `RSS_OFF_CTRL)
			ctrl_nxt = (ctrl_r & ~wMask) | (wData_r & wMask);
		else if (doWrite && awAddr_r == `RSS_OFF_CAPS)
			caps_nxt = (caps_r & ~wMask) | (wData_r & wMask);
		else if (doWrite && awAddr_r == `RSS_OFF_STATUS) begin
			if (wStrb_r[1] && wData_r[`RSS_ST_TFAIL])
				tFailSt_nxt = 1'b0;
			if (wStrb_r[1] && wData_r[`RSS_ST_OFAIL])
				oFailSt_nxt = 1'b0;
		end
		// A failure in the clearing cycle is kept
		if (tFailNote)
			tFailSt_nxt = 1'b1;
		if (oFailNote)
			oFailSt_nxt = 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r    <= `RSS_CTRL_RST;
			caps_r    <= `RSS_CAPS_RST;
			tFailSt_r <= 1'b0;
			oFailSt_r <= 1'b0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			caps_r    <= caps_nxt;
			tFailSt_r <= tFailSt_nxt;
			oFailSt_r <= oFailSt_nxt;
		end
	end

	always_comb begin
		rdMux    = 32'h00000000;
		rdMapped = 1'b1;
		if (araddr[31:2] == `RSS_OFF_CTRL >> 2)
			rdMux = {ctrl_r[31:8], ctrl_r[7:4] & 4'(2**AW - 1), ctrl_r[3:0]};
		else if (araddr[31:2] == `RSS_OFF_CAPS >> 2)
			rdMux = caps_r;
		else if (araddr[31:2] == `RSS_OFF_STATUS >> 2)
			rdMux = {18'h0, oFailSt_r, tFailSt_r, 3'h0, officeMarginFlag,
				1'b0, oState, 1'b0, tState};
		else if (araddr[31:2] == `RSS_OFF_ADVCAPS >> 2)
			rdMux = {16'(oAdvCaps), 16'(tAdvCaps)};
		else if (araddr[31:2] == `RSS_OFF_MODE >> 2)
			rdMux = {16'h0, 8'(officeMode_r), 8'(tModeSel)};
		else
			rdMapped = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Prescaler and per-half timers, 0 terminal side, 1 office side
	logic [PW-1:0] pre_r, pre_nxt;
	logic          tick_r, tick_nxt;
	logic [1:0]    longClr, hsClr, longExp, hsExp;

	always_comb begin
		pre_nxt  = pre_r + 1'b1;
		tick_nxt = 1'b0;
		if (pre_r == PW'(TICK_CYCLES - 1)) begin
			pre_nxt  = '0;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			pre_r  <= pre_nxt;
			tick_r <= tick_nxt;
		end
	end

	// Each half owns its segment, so timers never share state
	for (genvar g = 0; g < 2; g++) begin : gTmr
		logic [LW-1:0] longCnt_r, longCnt_nxt;
		logic [HW-1:0] hsCnt_r, hsCnt_nxt;
		always_comb begin
			longCnt_nxt = longCnt_r;
			hsCnt_nxt   = hsCnt_r;
			if (longClr[g])
				longCnt_nxt = '0;
			else if (tick_r && !longExp[g])
				longCnt_nxt = longCnt_r + 1'b1;
			if (hsClr[g])
				hsCnt_nxt = '0;
			else if (tick_r && !hsExp[g])
				hsCnt_nxt = hsCnt_r + 1'b1;
		end
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				longCnt_r <= '0;
				hsCnt_r   <= '0;
			end else begin
				longCnt_r <= longCnt_nxt;
				hsCnt_r   <= hsCnt_nxt;
			end
		end
		assign longExp[g] = longCnt_r == LW'(LONG_TICKS);
		assign hsExp[g]   = hsCnt_r == HW'(HS_TICKS);
	end

	////////////////////////////////////////////////////////////////////////
	// Internal link and both half state machines
	rss_term_state_type   tState_nxt;
	rss_office_state_type oState_nxt;
	logic [CAP_W-1:0]     tAdv_nxt, capsList_r, capsList_nxt, oAdv_nxt;
	logic [MODE_W-1:0]    tMode_nxt, oModeSel_nxt, officeMode_nxt;
	logic [MARGIN_W-1:0]  tMargin_nxt;
	logic tFlag_nxt, tStart_nxt, oStart_nxt, capsNote_nxt, linkNote_nxt;
	logic upNote_nxt, tFail_nxt, oFail_nxt, held_r, held_nxt, tSess, oSess;
	logic upOk;

	assign tSess = tState inside {T_HOLDA, T_HOLDB, T_CHECK, T_SESS2};
	assign oSess = oState inside {O_HOLDA, O_HOLDB, O_SESS1, O_SESS2};
	assign upOk  = clkMode == CM_1 ? (oActStart || oActDone) : oActDone;
	assign longClr = {oState == O_INITIAL_IDLE || oState == O_ACTIVE,
		tState == T_INITIAL_IDLE || tState == T_ACTIVE};
	assign hsClr = {!oSess || oState_nxt != oState,
		!tSess || tState_nxt != tState};

	always_comb begin
		tState_nxt   = tState;
		tAdv_nxt     = tAdvCaps;
		tFlag_nxt    = officeMarginFlag;
		tMode_nxt    = tModeSel;
		tStart_nxt   = 1'b0;
		capsNote_nxt = 1'b0;
		tFail_nxt    = 1'b0;
		capsList_nxt = capsList_r;
		case (tState)
		T_INITIAL_IDLE: begin
			tFlag_nxt = 1'b0;
			if (tRemoteInit)
				tState_nxt = T_HOLDA;
			else if (tOfficeInit)
				tState_nxt = T_HOLDB;
			else if (probeEn && held_r) begin
				tState_nxt = T_HOLDB;
				tStart_nxt = 1'b1;
			end
		end
		T_HOLDA:
			if (tSessOk)
				tState_nxt = probeEn ? T_INITIAL_IDLE : T_WAITOFF;
		T_HOLDB:
			if (held_r) begin
				tState_nxt = T_CHECK;
				tFlag_nxt  = 1'b1;
			end else if (tSessOk)
				tState_nxt = T_CHECK;
		T_CHECK:
			if (tSessOk)
				tState_nxt = T_WAITOFF;
		T_WAITOFF:
			if (officeUpNote) begin
				tState_nxt = T_SESS2;
				tMode_nxt  = officeMode_r;
				tStart_nxt = 1'b1;
			end else if (oFailNote && diagEn) begin
				tState_nxt = T_SESS2;
				tMode_nxt  = fbMode;
				tStart_nxt = 1'b1;
			end
		T_SESS2:
			if (tActDone)
				tState_nxt = T_ACTIVE;
		T_ACTIVE:
			if (tHsFail)
				tState_nxt = T_INITIAL_IDLE;
		default:
			tState_nxt = T_INITIAL_IDLE;
		endcase
		if (tState != T_INITIAL_IDLE && tState != T_ACTIVE &&
			(longExp[0] || tHsFail || (tSess && hsExp[0]))) begin
			tState_nxt = T_INITIAL_IDLE;
			tFail_nxt  = 1'b1;
			tStart_nxt = 1'b0;
		end
		if (tState_nxt != tState &&
			(tState_nxt == T_HOLDA || tState_nxt == T_WAITOFF)) begin
			capsNote_nxt = 1'b1;
			capsList_nxt = caps_r[CAP_W-1:0] & tPeerCaps &
				(probeEn ? tProbeCaps : {CAP_W{1'b1}});
			tAdv_nxt     = capsList_nxt;
		end
	end

	always_comb begin
		oState_nxt     = oState;
		oAdv_nxt       = oAdvCaps;
		oModeSel_nxt   = oSessOk ? oMode : oModeSel_r;
		officeMode_nxt = officeMode_r;
		oStart_nxt     = 1'b0;
		linkNote_nxt   = 1'b0;
		upNote_nxt     = 1'b0;
		oFail_nxt      = 1'b0;
		held_nxt       = held_r;
		tMargin_nxt    = tMargin;
		if (capsReadyNote)
			oAdv_nxt = caps_r[16 +: CAP_W] & capsList_r;
		case (oState)
		O_INITIAL_IDLE:
			if (capsReadyNote)
				oState_nxt = O_HOLDA;
			else if (oOfficeInit)
				oState_nxt = O_HOLDB;
		O_HOLDA:
			if (probeEn && held_r)
				oState_nxt = O_SESS1;
			else if (!probeEn && oSessOk)
				oState_nxt = O_WAITREM;
		O_HOLDB:
			if (oSessOk)
				oState_nxt = O_SESS2;
		O_SESS1:
			if (oSessOk)
				oState_nxt = O_WAITREM;
		O_WAITREM:
			if (oOfficeInit)
				oState_nxt = O_SESS2;
			else if (tFailNote && diagEn) begin
				oState_nxt = O_SESS2;
				oStart_nxt = 1'b1;
			end
		O_SESS2:
			if (upOk) begin
				oState_nxt     = O_ACTIVE;
				upNote_nxt     = 1'b1;
				officeMode_nxt = oModeSel_nxt;
			end
		O_ACTIVE:
			if (oHsFail)
				oState_nxt = O_INITIAL_IDLE;
		default:
			oState_nxt = O_INITIAL_IDLE;
		endcase
		if (oState != O_INITIAL_IDLE && oState != O_ACTIVE &&
			(longExp[1] || oHsFail || (oSess && hsExp[1]))) begin
			oState_nxt = O_INITIAL_IDLE;
			oFail_nxt  = 1'b1;
			oStart_nxt = 1'b0;
			upNote_nxt = 1'b0;
		end
		if (oState_nxt != oState &&
			(oState_nxt == O_WAITREM || oState_nxt == O_HOLDB))
			linkNote_nxt = 1'b1;
		// Stale margins must not restart a failed span
		if (tFail_nxt || oFail_nxt)
			held_nxt = 1'b0;
		if (oMarginValid && (oPeerIsOffice || oPeerMarginFlag)) begin
			held_nxt    = 1'b1;
			tMargin_nxt = oMargin;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tState           <= T_INITIAL_IDLE;
			oState           <= O_INITIAL_IDLE;
			tAdvCaps         <= '0;
			oAdvCaps         <= '0;
			capsList_r       <= '0;
			officeMarginFlag <= 1'b0;
			tModeSel         <= '0;
			oModeSel_r       <= '0;
			officeMode_r     <= '0;
			tMargin          <= '0;
			held_r           <= 1'b0;
			tStartHs         <= 1'b0;
			oStartHs         <= 1'b0;
			capsReadyNote    <= 1'b0;
			linkStartNote    <= 1'b0;
			officeUpNote     <= 1'b0;
			tFailNote        <= 1'b0;
			oFailNote        <= 1'b0;
		end else begin
			tState           <= tState_nxt;
			oState           <= oState_nxt;
			tAdvCaps         <= tAdv_nxt;
			oAdvCaps         <= oAdv_nxt;
			capsList_r       <= capsList_nxt;
			officeMarginFlag <= tFlag_nxt;
			tModeSel         <= tMode_nxt;
			oModeSel_r       <= oModeSel_nxt;
			officeMode_r     <= officeMode_nxt;
			tMargin          <= tMargin_nxt;
			held_r           <= held_nxt;
			tStartHs         <= tStart_nxt;
			oStartHs         <= oStart_nxt;
			capsReadyNote    <= capsNote_nxt;
			linkStartNote    <= linkNote_nxt;
			officeUpNote     <= upNote_nxt;
			tFailNote        <= tFail_nxt;
			oFailNote        <= oFail_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence sWaitUp;
		tState == T_WAITOFF && officeUpNote;
	endsequence

	a_caps_notice_entry: assert property (capsReadyNote |->
		(tState == T_HOLDA || tState == T_WAITOFF) && $changed(tState))
		else $error("caps notice outside hold A or wait-office entry");
	a_caps_subset: assert property (capsReadyNote |->
		(capsList_r & ~$past(tPeerCaps)) == '0)
		else $error("caps list exceeds peer caps");
	a_mode_reuse: assert property (sWaitUp ##1 tState == T_SESS2 |->
		tModeSel == $past(officeMode_r) && tStartHs)
		else $error("terminal half did not reuse office mode");
	a_term_long_to: assert property (longExp[0] && tState != T_INITIAL_IDLE &&
		tState != T_ACTIVE |=> tState == T_INITIAL_IDLE && tFailNote)
		else $error("terminal long timeout not honoured");
	a_office_hs_to: assert property (hsExp[1] && oSess |=>
		oState == O_INITIAL_IDLE && oFailNote)
		else $error("office handshake timeout not honoured");
	a_term_diag: assert property (tState == T_WAITOFF && oFailNote &&
		diagEn && !officeUpNote && !longExp[0] && !tHsFail |=>
		tState == T_SESS2 && tStartHs && tModeSel == $past(fbMode))
		else $error("terminal fallback did not start session two");
	a_link_start: assert property ($changed(oState) &&
		(oState == O_WAITREM || oState == O_HOLDB) |-> linkStartNote)
		else $error("link start notice missing");
	a_margin_block: assert property (oMarginValid && !oPeerIsOffice &&
		!oPeerMarginFlag && !held_r |=> !held_r)
		else $error("untagged margins forwarded");
	a_office_up: assert property (officeUpNote |->
		oState == O_ACTIVE && officeMode_r == oModeSel_r)
		else $error("office up without matching mode");
	a_clock_gate: assert property (officeUpNote && clkMode != CM_1 |->
		$past(oActDone))
		else $error("active signalled before activation done");
endmodule

/* rss_line_peer.sv */
// Line-side handshake engines facing both halves of the sequencer.
// Assumes the bench calls fire() and setLv() just after a rising edge.
`timescale 1ns/1ps
module rss_line_peer (
	input	wire logic	clk,
	output	logic		tRemoteInit,
	output	logic		tOfficeInit,
	output	logic		tSessOk,
	output	logic		tActDone,
	output	logic		tHsFail,
	output	logic		oOfficeInit,
	output	logic		oMarginValid,
	output	logic		oSessOk,
	output	logic		oActStart,
	output	logic		oActDone,
	output	logic		oHsFail,
	output	logic [15:0]	tPeerCaps,
	output	logic [15:0]	tProbeCaps,
	output	logic [7:0]	oMargin,
	output	logic [7:0]	oMode,
	output	logic		oPeerIsOffice,
	output	logic		oPeerMarginFlag
);
	logic [10:0]	ev = 11'h000;
	// Failures only on command; a silenced office peer reports none
	assign {oHsFail, oActDone, oActStart, oSessOk, oMarginValid,
		oOfficeInit, tHsFail, tActDone, tSessOk, tOfficeInit,
		tRemoteInit} = ev;
	initial setLv(16'h0000, 16'h0000, 8'h00, 8'h00, 1'h1, 1'h0);
	////////////////////////////////////////////////////////////
	task automatic setLv(input logic [15:0] pc, qc,
		input logic [7:0] mg, md, input logic io, pf);
		{tPeerCaps, tProbeCaps, oMargin, oMode} <= {pc, qc, mg, md};
		{oPeerIsOffice, oPeerMarginFlag} <= {io, pf};
	endtask
	// Slow answers wait dly edges; events never closer than one idle cycle
	task automatic fire(input int k, dly);
		repeat (dly) @(posedge clk);
		@(posedge clk);
		ev <= 11'h001 << k;
		@(posedge clk);
		ev <= 11'h000;
	endtask
endmodule

/* rss_top_bench.sv */
// Self-checking bench for the regenerator start-up sequencer.
// Assumes rss_line_peer drives every line-side input of the design.
`timescale 1ns/1ps
`include "rss_cfg.svh"
module rss_top_bench;
	import rss_pkg::*;
	logic			clk = 1'h0;
	logic			reset_n = 1'h0;
	logic [31:0]		awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic [3:0]		wstrb = 4'h0;
	logic			awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic			arvalid = 1'h0, rready = 1'h0;
	logic			awready, wready, bvalid, arready, rvalid;
	logic [1:0]		bresp, rresp;
	logic			tRemoteInit, tOfficeInit, tSessOk, tActDone, tHsFail;
	logic			oOfficeInit, oMarginValid, oSessOk, oActStart, oActDone;
	logic			oHsFail, oPeerIsOffice, oPeerMarginFlag, officeMarginFlag;
	logic			tStartHs, oStartHs, capsReadyNote, linkStartNote;
	logic			officeUpNote, tFailNote, oFailNote;
	logic [15:0]		tPeerCaps, tProbeCaps, tAdvCaps, oAdvCaps;
	logic [7:0]		oMargin, oMode, tMargin, tModeSel;
	rss_term_state_type	tState;
	rss_office_state_type	oState;
	int			err_total = 0, total_checks = 0, nN[5], s0[5];
	int			ex[5] = '{2, 1, 1, 1, 0};
	wire [4:0]		note = {oStartHs, tStartHs, officeUpNote,
		linkStartNote, capsReadyNote};

	rss_top #(.TICK_CYCLES(2), .LONG_TICKS(40), .HS_TICKS(10)) dut (.*);
	rss_line_peer peer (.*);

	always #5 clk = ~clk;
	// Pulses last one cycle, so they are counted rather than sampled
	always @(posedge clk)
		foreach (nN[i])
			nN[i] <= nN[i] + int'(note[i]);
	////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rst();
		@(posedge clk);
		reset_n <= 1'h0;
		repeat (2) @(posedge clk);
		reset_n <= 1'h1;
	endtask
	task automatic axw(input logic [31:0] a, d, input logic [3:0] s,
		input logic [1:0] r);
		logic ad = 1'h0, wd = 1'h0;
		@(posedge clk);
		{awaddr, wdata, wstrb} <= {a, d, s};
		{awvalid, wvalid} <= 2'h3;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (awvalid && awready) begin
				ad = 1'h1;
				awvalid <= 1'h0;
			end
			if (wvalid && wready) begin
				wd = 1'h1;
				wvalid <= 1'h0;
			end
		end
		bready <= 1'h1;
		do @(posedge clk); while (!bvalid);
		bready <= 1'h0;
		chk("bresp", r, bresp);
	endtask
	// Masked compare: only the fields under test are judged
	task automatic axr(input logic [31:0] a, e, m, input logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'h0;
		rready <= 1'h1;
		do @(posedge clk); while (!rvalid);
		rready <= 1'h0;
		chk("rresp", r, rresp);
		chk("rdata", e, rdata & m);
	endtask
	task automatic tally_and_finish();
		if (err_total == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		rst();
		axr(`RSS_OFF_STATUS, 32'h0, 32'hFFFFFFFF, 2'h0);
		axr(`RSS_OFF_CAPS, 32'hFFFFFFFF, 32'hFFFFFFFF, 2'h0);
		axw(`RSS_OFF_CTRL, 32'h000000F4, 4'hF, 2'h0);
		axr(`RSS_OFF_CTRL, 32'h00000074, 32'hFFFFFFFF, 2'h0);
		axw(32'h00000040, 32'h1, 4'hF, 2'h2);
		axr(32'h00000040, 32'h0, 32'hFFFFFFFF, 2'h2);
		axw(`RSS_OFF_CAPS, 32'h0F0F3C3C, 4'hF, 2'h0);
		peer.setLv(16'h0FF0, 16'h00F0, 8'h5A, 8'hA5, 1'h1, 1'h0);
		peer.fire(0, 0);
		@(negedge clk);
		chk("tState", T_HOLDA, tState);
		axr(`RSS_OFF_ADVCAPS, 32'h0C000C30, 32'hFFFFFFFF, 2'h0);
		peer.fire(2, 0);
		// Nothing more arrives, so the long timer must give up
		repeat (110) @(posedge clk);
		chk("tState", T_INITIAL_IDLE, tState);
		axr(`RSS_OFF_STATUS, 32'h1000, 32'h1077, 2'h0);
		axw(`RSS_OFF_STATUS, 32'h1000, 4'h2, 2'h0);
		axr(`RSS_OFF_STATUS, 32'h0, 32'h1000, 2'h0);
		s0 = nN;
		peer.fire(0, 0);
		peer.fire(2, 0);
		@(negedge clk);
		chk("tState", T_WAITOFF, tState);
		peer.fire(7, 3);
		peer.fire(5, 0);
		peer.fire(8, 0);
		@(negedge clk);
		chk("oState", O_SESS2, oState);
		peer.fire(9, 0);
		repeat (2) @(negedge clk);
		chk("oState", O_ACTIVE, oState);
		chk("tModeSel", 32'hA5, tModeSel);
		axr(`RSS_OFF_MODE, 32'hA5A5, 32'hFFFF, 2'h0);
		peer.fire(3, 0);
		@(negedge clk);
		chk("tState", T_ACTIVE, tState);
		for (int i = 0; i < 5; i++)
			chk("notes", ex[i], nN[i] - s0[i]);
		rst();
		axw(`RSS_OFF_CTRL, 32'h00003C06, 4'hF, 2'h0);
		peer.fire(0, 0);
		peer.fire(2, 0);
		peer.fire(10, 0);
		repeat (3) @(negedge clk);
		chk("tState", T_SESS2, tState);
		chk("tModeSel", 32'h3C, tModeSel);
		rst();
		axw(`RSS_OFF_CTRL, 32'h00000003, 4'hF, 2'h0);
		peer.setLv(16'h0FF0, 16'h00F0, 8'h33, 8'hA5, 1'h0, 1'h0);
		peer.fire(0, 0);
		peer.fire(2, 0);
		peer.fire(6, 0);
		@(negedge clk);
		chk("tState", T_INITIAL_IDLE, tState);
		chk("tMargin", 32'h0, tMargin);
		chk("tAdvCaps", 32'h00F0, tAdvCaps);
		@(posedge clk);
		peer.setLv(16'h0FF0, 16'h00F0, 8'h5A, 8'hA5, 1'h0, 1'h1);
		peer.fire(6, 0);
		repeat (3) @(negedge clk);
		chk("tState", T_CHECK, tState);
		chk("oState", O_SESS1, oState);
		chk("officeMarginFlag", 32'h1, officeMarginFlag);
		chk("tMargin", 32'h5A, tMargin);
		peer.fire(7, 0);
		peer.fire(4, 0);
		repeat (2) @(negedge clk);
		chk("oState", O_SESS2, oState);
		chk("oStartHs", 32'h1, oStartHs);
		chk("tState", T_INITIAL_IDLE, tState);
		peer.fire(8, 0);
		@(negedge clk);
		chk("oState", O_ACTIVE, oState);
		tally_and_finish();
	end
	initial begin
		repeat (4000) @(posedge clk);
		err_total++;
		tally_and_finish();
	end
endmodule
